// ---- sfbm_pkg.sv ----
// Shared constants of the serial flash link: opcodes, sizes, timing.
// Assumes both ends run on sys_clk at 250 MHz.
package sfbm_pkg;
  localparam logic [7:0] OP_ENTER4 = 8'h35;
  localparam logic [7:0] OP_EXIT4 = 8'hf5;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_DTR_READ = 8'h0d;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERS_4K = 8'h20;
  localparam logic [7:0] OP_ERS_32K = 8'h52;
  localparam logic [7:0] OP_ERS_64K = 8'hd8;
  localparam logic [7:0] OP_ERS_ALL = 8'hc7;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam int ARRAY_BITS = 21;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [23:0] ERS_M4K = 24'h000fff;
  localparam logic [23:0] ERS_M32K = 24'h007fff;
  localparam logic [23:0] ERS_M64K = 24'h00ffff;
  localparam logic [23:0] PAGE_M = 24'h0000ff;
  localparam logic [23:0] WRAP_NONE = 24'hffffff;
  localparam logic [23:0] WRAP_M8 = 24'h000007;
  localparam logic [23:0] WRAP_M16 = 24'h00000f;
  localparam logic [23:0] WRAP_M32 = 24'h00001f;
  localparam logic [23:0] WRAP_M64 = 24'h00003f;
  localparam logic [2:0] WRAP_SEL_8 = 3'h1;
  localparam logic [2:0] WRAP_SEL_16 = 3'h2;
  localparam logic [2:0] WRAP_SEL_32 = 3'h3;
  localparam logic [2:0] WRAP_SEL_64 = 3'h4;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] OPC_BEATS_1 = 5'h08;
  localparam logic [4:0] OPC_BEATS_4 = 5'h02;
  localparam logic [4:0] ADR_BEATS_1 = 5'h18;
  localparam logic [4:0] ADR_BEATS_4 = 5'h06;
  localparam int SYS_CLK_MHZ = 250;
  localparam int LINK_PERIOD_NS = 64;
  localparam int HALF_CYC = LINK_PERIOD_NS * SYS_CLK_MHZ / 2000;

  function automatic logic needsAddr(input logic [7:0] op);
    return op == OP_READ || op == OP_DTR_READ || op == OP_PROG ||
      op == OP_ERS_4K || op == OP_ERS_32K || op == OP_ERS_64K;
  endfunction

  function automatic logic isRead(input logic [7:0] op);
    return op == OP_READ || op == OP_DTR_READ;
  endfunction

  function automatic logic isDtr(input logic [7:0] op);
    return op == OP_DTR_READ;
  endfunction

  function automatic logic [23:0] wrapMask(input logic [2:0] sel);
    case (sel)
      WRAP_SEL_8: return WRAP_M8;
      WRAP_SEL_16: return WRAP_M16;
      WRAP_SEL_32: return WRAP_M32;
      WRAP_SEL_64: return WRAP_M64;
      default: return WRAP_NONE;
    endcase
  endfunction
endpackage

// ---- sfbm_link_if.sv ----
// Link between flash controller and flash device: clock, select, 4 lines.
// Assumes an undriven data line floats high through a pull-up.
`timescale 1ns/100ps
interface sfbm_link_if;
  logic sck;
  logic csN;
  logic [3:0] hostDo;
  logic [3:0] hostOeN;
  logic [3:0] devDo;
  logic [3:0] devOeN;
  logic [3:0] dq;

  // Device first, then host, else pulled high
  assign dq = (~devOeN & devDo) | (devOeN & ~hostOeN & hostDo) |
    (devOeN & hostOeN);

  modport dev (input sck, csN, dq, output devDo, devOeN);
  modport host (output sck, csN, hostDo, hostOeN, input dq);
endinterface

// ---- sfbm_host.sv ----
// Flash controller end: FIFO for read data and the link master.
// Assumes sfbm_pkg and sfbm_link_if; link pins are resolved in the interface.
`timescale 1ns/100ps
module sfbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } sfbm_fifo_s;
  sfbm_fifo_s s_ff, nxt_s;
  logic push, pop;

  assign inReady = s_ff.cnt != (AW+1)'(DEPTH);
  assign outValid = s_ff.cnt != '0;
  assign outData = s_ff.mem[s_ff.rd];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = inData;
      nxt_s.wr = s_ff.wr == AW'(DEPTH - 1) ? '0 : s_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd = s_ff.rd == AW'(DEPTH - 1) ? '0 : s_ff.rd + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sysClk) begin
    if (!rstn) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end
endmodule

module sfbm_host #(
  parameter int HALF = sfbm_pkg::HALF_CYC,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdOp,
  input wire logic [23:0] cmdAddr,
  input wire logic [8:0] cmdLen,
  input wire logic cmdMode3,
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire logic rdReady,
  output logic quadMode,
  output logic frameBusy,
  sfbm_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_LEAD = 3'b001, H_OPC = 3'b010, H_ADR = 3'b011,
    H_DAT = 3'b100, H_TAIL = 3'b101, H_GAP = 3'b110
  } sfbm_host_st_e;
  typedef struct packed {
    sfbm_host_st_e st;
    logic [7:0] tmr;
    logic phB;
    logic quad;
    logic rstArm;
    logic mode3;
    logic dtr;
    logic rd;
    logic wr;
    logic [7:0] op;
    logic [31:0] sr;
    logic [7:0] rx;
    logic [4:0] bl;
    logic [8:0] len;
    logic [3:0] dqS1;
    logic [3:0] dqS2;
    logic sck;
    logic csN;
    logic [3:0] dOut;
    logic [3:0] oeN;
    logic push;
    logic [7:0] pushD;
  } sfbm_host_s;
  localparam sfbm_host_s RST_S = '{st: H_IDLE, csN: 1'b1, oeN: 4'hf,
    default: '0};
  sfbm_host_s s_ff, nxt_s;
  logic fifoInReady, beat, mid, endPh, byteStart, stall, drives;
  logic [4:0] bpb, blNew;
  logic [7:0] rxNew;

  sfbm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sysClk(sysClk),
    .rstn(rstn),
    .ce(ce),
    .inValid(s_ff.push),
    .inData(s_ff.pushD),
    .inReady(fifoInReady),
    .outValid(rdValid),
    .outData(rdData),
    .outReady(rdReady)
  );

  assign cmdReady = s_ff.st == H_IDLE;
  assign quadMode = s_ff.quad;
  assign frameBusy = !s_ff.csN;
  assign link.sck = s_ff.sck;
  assign link.csN = s_ff.csN;
  assign link.hostDo = s_ff.dOut;
  assign link.hostOeN = s_ff.oeN;
  assign bpb = s_ff.quad ? sfbm_pkg::OPC_BEATS_4 : sfbm_pkg::OPC_BEATS_1;
  assign beat = !s_ff.phB || (s_ff.dtr && s_ff.st != H_OPC);
  assign mid = s_ff.tmr == 8'(HALF / 2);
  assign endPh = s_ff.tmr == 8'(HALF - 1);
  assign byteStart = s_ff.st == H_DAT && s_ff.bl == bpb && !s_ff.phB &&
    s_ff.tmr == 8'h00;
  assign stall = byteStart && ((s_ff.wr && !wrValid) ||
    (s_ff.rd && !fifoInReady));
  assign wrReady = byteStart && s_ff.wr;
  assign drives = s_ff.st == H_OPC || s_ff.st == H_ADR ||
    (s_ff.st == H_DAT && s_ff.wr);
  assign blNew = s_ff.bl - 5'h01;
  assign rxNew = s_ff.quad ? {s_ff.rx[3:0], s_ff.dqS2} :
    {s_ff.rx[6:0], s_ff.dqS2[1]};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.dqS1 = link.dq;
    nxt_s.dqS2 = s_ff.dqS1;
    nxt_s.push = 1'b0;
    unique case (s_ff.st)
      H_IDLE: begin
        if (cmdValid) begin
          nxt_s.st = H_LEAD;
          nxt_s.tmr = 8'h00;
          nxt_s.op = cmdOp;
          nxt_s.sr = {cmdOp, cmdAddr};
          nxt_s.len = cmdLen;
          nxt_s.mode3 = cmdMode3;
          nxt_s.dtr = sfbm_pkg::isDtr(cmdOp);
          nxt_s.rd = sfbm_pkg::isRead(cmdOp);
          nxt_s.wr = cmdOp == sfbm_pkg::OP_PROG;
        end
      end
      H_LEAD, H_TAIL, H_GAP: begin
        nxt_s.tmr = s_ff.tmr + 8'h01;
        if (endPh) begin
          nxt_s.tmr = 8'h00;
          nxt_s.phB = 1'b0;
          if (s_ff.st == H_LEAD) begin
            nxt_s.st = H_OPC;
            nxt_s.bl = bpb;
          end else if (s_ff.st == H_TAIL) begin
            nxt_s.st = H_GAP;
            nxt_s.rstArm = s_ff.op == sfbm_pkg::OP_RST_EN;
            if (s_ff.op == sfbm_pkg::OP_ENTER4) begin
              nxt_s.quad = 1'b1;
            end else if (s_ff.op == sfbm_pkg::OP_EXIT4 ||
                (s_ff.op == sfbm_pkg::OP_RST && s_ff.rstArm)) begin
              nxt_s.quad = 1'b0;
            end
          end else begin
            nxt_s.st = H_IDLE;
          end
        end
      end
      default: begin
        if (!stall) begin
          nxt_s.tmr = s_ff.tmr + 8'h01;
          if (byteStart && s_ff.wr) begin
            nxt_s.sr[31:24] = wrData;
          end
          if (mid && beat && drives) begin
            nxt_s.dOut = s_ff.quad ? s_ff.sr[31:28] : {3'h0, s_ff.sr[31]};
            nxt_s.sr = s_ff.quad ? {s_ff.sr[27:0], 4'h0} :
              {s_ff.sr[30:0], 1'b0};
          end
          if (endPh) begin
            nxt_s.tmr = 8'h00;
            nxt_s.phB = !s_ff.phB;
            if (beat) begin
              nxt_s.rx = rxNew;
              nxt_s.bl = blNew;
              if (s_ff.st == H_DAT && blNew == 5'h00) begin
                nxt_s.push = s_ff.rd;
                nxt_s.pushD = rxNew;
                if (s_ff.len > 9'h001) begin
                  nxt_s.len = s_ff.len - 9'h001;
                  nxt_s.bl = bpb;
                end
              end
            end
            if (s_ff.phB && nxt_s.bl == 5'h00) begin
              if (s_ff.st == H_OPC && sfbm_pkg::needsAddr(s_ff.op)) begin
                nxt_s.st = H_ADR;
                nxt_s.bl = s_ff.quad ? sfbm_pkg::ADR_BEATS_4 :
                  sfbm_pkg::ADR_BEATS_1;
              end else if (s_ff.st != H_DAT && s_ff.len != 9'h000) begin
                nxt_s.st = H_DAT;
                nxt_s.bl = bpb;
              end else begin
                nxt_s.st = H_TAIL;
              end
            end
          end
        end
      end
    endcase
    nxt_s.csN = nxt_s.st == H_IDLE || nxt_s.st == H_GAP;
    nxt_s.sck = (nxt_s.st == H_OPC || nxt_s.st == H_ADR ||
      nxt_s.st == H_DAT) ? nxt_s.phB : nxt_s.mode3;
    if (nxt_s.csN) begin
      nxt_s.oeN = 4'hf;
    end else if (!nxt_s.quad) begin
      nxt_s.oeN = 4'he;
    end else begin
      nxt_s.oeN = (nxt_s.st == H_OPC || nxt_s.st == H_ADR ||
        (nxt_s.st == H_DAT && nxt_s.wr)) ? 4'h0 : 4'hf;
    end
  end

  always_ff @(posedge sysClk) begin
    if (!rstn) begin
      s_ff <= RST_S;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ---- sfbm_flash_dev.sv ----
// Flash device end: command decode, mode switch, array read/program/erase.
// Assumes sfbm_pkg and sfbm_link_if; link pins come from another domain.
// Notes on behaviour
// - Single line: bits sampled on rising clock
// - Clock may idle low or high
// - Opcode 35h enters four-line command mode
// - Opcode F5h leaves it, quad allow ignored
// - Opcode: two clocks four-line, eight single
// - Exactly one interface mode active
// - Any reset returns to single-line mode
// - Four-line mode uses all four lines
// - Double-edge read: address, data on both
// - Single-line read data only on line 1
// - Program one to 256 bytes in page
// - Erase 4K, 32K, 64K or whole array
// - Erased and delivered bytes read all ones
// - Read wraps in 8/16/32/64 byte window
`timescale 1ns/100ps
module sfbm_flash_dev #(
  parameter int ARRAY_BITS = sfbm_pkg::ARRAY_BITS
) (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [2:0] wrapSel,
  output logic quadMode,
  output logic busy,
  sfbm_link_if.dev link
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_OPC = 3'b001,
    D_ADR = 3'b010,
    D_DOUT = 3'b011,
    D_DIN = 3'b100,
    D_SKIP = 3'b101,
    D_ERASE = 3'b110
  } sfbm_dev_st_e;
  typedef struct packed {
    sfbm_dev_st_e st;
    logic [2:0] sckS;
    logic [1:0] csS;
    logic [3:0] dqS1;
    logic [3:0] dqS2;
    logic quad;
    logic rstArm;
    logic dtr;
    logic ersArm;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] sr;
    logic [4:0] cnt;
    logic [3:0] dOut;
    logic [3:0] dOeN;
    logic [23:0] ersAddr;
    logic [23:0] ersMask;
  } sfbm_dev_s;
  localparam sfbm_dev_s RST_S = '{st: D_IDLE, csS: 2'h3, dOeN: 4'hf,
    default: '0};
  localparam logic [23:0] ALL_M = 24'((25'h1 << ARRAY_BITS) - 25'h1);

  sfbm_dev_s s_ff, nxt_s;
  logic [7:0] mem [2**ARRAY_BITS];
  logic rise, fall, csHigh, drive;
  logic [4:0] step;
  logic [7:0] bitsIn, cur;
  logic [23:0] wm;
  logic memWe;
  logic [ARRAY_BITS-1:0] memWa;
  logic [7:0] memWd;

  // Array starts erased
  initial begin
    foreach (mem[i]) begin
      mem[i] = sfbm_pkg::ERASED;
    end
  end

  assign quadMode = s_ff.quad;
  assign busy = s_ff.st == D_ERASE;
  assign link.devDo = s_ff.dOut;
  assign link.devOeN = s_ff.dOeN;
  // Edge finding on the synchronised clock, either idle level
  assign rise = s_ff.sckS[1] && !s_ff.sckS[2];
  assign fall = !s_ff.sckS[1] && s_ff.sckS[2];
  assign csHigh = s_ff.csS[1];
  assign step = s_ff.quad ? 5'h04 : 5'h01;
  assign bitsIn = s_ff.quad ? {s_ff.sr[3:0], s_ff.dqS2} :
    {s_ff.sr[6:0], s_ff.dqS2[0]};
  assign wm = sfbm_pkg::wrapMask(wrapSel);

  always_comb begin
    nxt_s = s_ff;
    drive = 1'b0;
    memWe = 1'b0;
    memWa = s_ff.addr[ARRAY_BITS-1:0];
    memWd = sfbm_pkg::ERASED;
    nxt_s.sckS = {s_ff.sckS[1:0], link.sck};
    nxt_s.csS = {s_ff.csS[0], link.csN};
    nxt_s.dqS1 = link.dq;
    nxt_s.dqS2 = s_ff.dqS1;
    if (csHigh && s_ff.st != D_ERASE && s_ff.st != D_IDLE) begin
      nxt_s.st = s_ff.ersArm ? D_ERASE : D_IDLE;
      nxt_s.ersArm = 1'b0;
      nxt_s.dOeN = 4'hf;
    end else begin
      unique case (s_ff.st)
        D_IDLE: begin
          if (!csHigh) begin
            nxt_s.st = D_OPC;
            nxt_s.cnt = 5'h00;
            nxt_s.dtr = 1'b0;
            nxt_s.ersArm = 1'b0;
          end
        end
        D_OPC: begin
          if (rise) begin
            nxt_s.sr = bitsIn;
            nxt_s.cnt = s_ff.cnt + step;
            if (s_ff.cnt + step == sfbm_pkg::BYTE_BITS) begin
              nxt_s.op = bitsIn;
              nxt_s.cnt = 5'h00;
              nxt_s.st = D_SKIP;
              nxt_s.rstArm = bitsIn == sfbm_pkg::OP_RST_EN;
              if (bitsIn == sfbm_pkg::OP_ENTER4) begin
                nxt_s.quad = 1'b1;
              end else if (bitsIn == sfbm_pkg::OP_EXIT4) begin
                nxt_s.quad = 1'b0;
              end else if (bitsIn == sfbm_pkg::OP_RST && s_ff.rstArm) begin
                nxt_s.quad = 1'b0;
              end else if (bitsIn == sfbm_pkg::OP_ERS_ALL) begin
                nxt_s.ersArm = 1'b1;
                nxt_s.ersAddr = 24'h000000;
                nxt_s.ersMask = ALL_M;
              end else if (sfbm_pkg::needsAddr(bitsIn)) begin
                nxt_s.st = D_ADR;
                nxt_s.dtr = sfbm_pkg::isDtr(bitsIn);
              end
            end
          end
        end
        D_ADR: begin
          // First address bit comes on a rise, so skip the fall before it
          if (rise || (s_ff.dtr && fall && s_ff.cnt != 5'h00)) begin
            nxt_s.addr = s_ff.quad ? {s_ff.addr[19:0], s_ff.dqS2} :
              {s_ff.addr[22:0], s_ff.dqS2[0]};
            nxt_s.cnt = s_ff.cnt + step;
            if (s_ff.cnt + step == sfbm_pkg::ADDR_BITS) begin
              nxt_s.cnt = 5'h00;
              if (sfbm_pkg::isRead(s_ff.op)) begin
                nxt_s.st = D_DOUT;
                drive = s_ff.dtr;
              end else if (s_ff.op == sfbm_pkg::OP_PROG) begin
                nxt_s.st = D_DIN;
              end else begin
                nxt_s.st = D_SKIP;
                nxt_s.ersArm = 1'b1;
                unique case (s_ff.op)
                  sfbm_pkg::OP_ERS_4K: nxt_s.ersMask = sfbm_pkg::ERS_M4K;
                  sfbm_pkg::OP_ERS_32K: nxt_s.ersMask = sfbm_pkg::ERS_M32K;
                  default: nxt_s.ersMask = sfbm_pkg::ERS_M64K;
                endcase
                // Walk no further than the array holds
                nxt_s.ersMask = nxt_s.ersMask & ALL_M;
                nxt_s.ersAddr = nxt_s.addr & ~nxt_s.ersMask;
              end
            end
          end
        end
        D_DOUT: begin
          drive = fall || (s_ff.dtr && rise);
        end
        D_DIN: begin
          if (rise) begin
            nxt_s.sr = bitsIn;
            nxt_s.cnt = s_ff.cnt + step;
            if (s_ff.cnt + step == sfbm_pkg::BYTE_BITS) begin
              nxt_s.cnt = 5'h00;
              memWe = 1'b1;
              memWd = mem[s_ff.addr[ARRAY_BITS-1:0]] & bitsIn;
              // Column wraps so a burst stays in its page
              nxt_s.addr = (s_ff.addr & ~sfbm_pkg::PAGE_M) |
                ((s_ff.addr + 24'h1) & sfbm_pkg::PAGE_M);
            end
          end
        end
        D_SKIP: begin
          nxt_s.dOeN = 4'hf;
        end
        D_ERASE: begin
          memWe = 1'b1;
          memWa = s_ff.ersAddr[ARRAY_BITS-1:0];
          memWd = sfbm_pkg::ERASED;
          if ((s_ff.ersAddr & s_ff.ersMask) == s_ff.ersMask) begin
            nxt_s.st = csHigh ? D_IDLE : D_SKIP;
          end else begin
            nxt_s.ersAddr = s_ff.ersAddr + 24'h1;
          end
        end
        default: begin
          nxt_s.st = D_IDLE;
        end
      endcase
    end
    cur = nxt_s.cnt == 5'h00 ? mem[nxt_s.addr[ARRAY_BITS-1:0]] : nxt_s.sr;
    if (drive) begin
      if (nxt_s.cnt == 5'h00) begin
        nxt_s.addr = (nxt_s.addr & ~wm) |
          ((nxt_s.addr + 24'h1) & wm);
      end
      nxt_s.cnt = (nxt_s.cnt == 5'h00 ? sfbm_pkg::BYTE_BITS : nxt_s.cnt) -
        step;
      if (s_ff.quad) begin
        nxt_s.dOut = cur[7:4];
        nxt_s.dOeN = 4'h0;
        nxt_s.sr = {cur[3:0], 4'h0};
      end else begin
        nxt_s.dOut = {2'h0, cur[7], 1'b0};
        nxt_s.dOeN = 4'hd;
        nxt_s.sr = {cur[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sysClk) begin
    if (ce && memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // One mode bit, cleared by reset
  always_ff @(posedge sysClk) begin
    if (!rstn) begin
      s_ff <= RST_S;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ---- sfbm_link_props.sv ----
// Checker for the flash link: select, clock, line drive and reset state.
// Assumes it sits beside the link interface and sees the host mode flag.
`timescale 1ns/100ps
module sfbm_link_props (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic quadMode,
  input wire logic sck,
  input wire logic csN,
  input wire logic [3:0] hostDo,
  input wire logic [3:0] hostOeN,
  input wire logic [3:0] devOeN
);
  logic sckP_ff;
  logic csP_ff;
  logic fQuad_ff;
  logic [11:0] rise_ff;

  // Rising link clock edges in the current frame
  always_ff @(posedge sysClk) begin
    sckP_ff <= sck;
    csP_ff <= csN;
    if (csP_ff && !csN) fQuad_ff <= quadMode;
    if (csN) rise_ff <= 12'h000;
    else if (!csP_ff && sck && !sckP_ff) rise_ff <= rise_ff + 12'h001;
  end

  default clocking @(posedge sysClk); endclocking
  default disable iff (!rstn);

  sequence sFrameStart;
    $fell(csN);
  endsequence
  sequence sLead;
    $stable(sck)[*4];
  endsequence
  sequence sFrameEnd;
    $rose(csN);
  endsequence

  a_lead_clock_idle: assert property (sFrameStart |=> sLead)
    else $error("clock moved right after select");
  a_idle_clock_held: assert property (csN && $past(csN) |->
    $stable(sck))
    else $error("clock moved while deselected");
  a_rise_data_held: assert property ($rose(sck) && !csN |->
    $stable(hostDo))
    else $error("host data changed on rising clock");
  a_single_out_line: assert property (!csN && !quadMode &&
    !$past(quadMode, 4) |-> devOeN[0] && (&devOeN[3:2]))
    else $error("device drove a line other than line 1");
  a_single_in_line: assert property (!csN && !quadMode &&
    !$past(quadMode, 4) |-> &hostOeN[3:1])
    else $error("host drove a line other than line 0");
  a_no_line_fight: assert property ((~devOeN & ~hostOeN) == 4'h0)
    else $error("both ends drove one line");
  a_opcode_beats: assert property (sFrameEnd |->
    rise_ff >= (fQuad_ff ? 12'h002 : 12'h008))
    else $error("frame shorter than an opcode");
  a_select_release: assert property (sFrameEnd |->
    ##[0:6] (devOeN == 4'hf))
    else $error("device kept driving after deselect");
  a_reset_idle: assert property ($rose(rstn) |-> csN &&
    (&hostOeN) && (&devOeN) && !quadMode)
    else $error("link not idle after reset");
endmodule

// ---- testbench.sv ----
// Bench joining the flash controller and flash device over the link.
// Assumes the package, link interface and both ends are compiled first.
`timescale 1ns/100ps
module testbench;
  logic sysClk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdMode3 = 1'b0;
  logic wrValid = 1'b0;
  logic rdReady = 1'b0;
  logic [7:0] cmdOp = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic [23:0] cmdAddr = 24'h000000;
  logic [8:0] cmdLen = 9'h000;
  logic [2:0] wrapSel = 3'h0;
  logic cmdReady, wrReady, rdValid, hQuad, dQuad, frameBusy, dBusy;
  logic [7:0] rdData;
  logic sckP, csP;
  logic [15:0] rises = 16'h0000;
  logic [15:0] frameRises = 16'h0000;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] wrQ[$];
  logic [7:0] rdQ[$];
  logic [7:0] noBytes[$];
  logic [7:0] q[$];

  sfbm_link_if link();
  sfbm_host sfbm_host_inst (.sysClk(sysClk), .rstn(rstn), .ce(1'b1),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdMode3(cmdMode3),
    .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
    .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady),
    .quadMode(hQuad), .frameBusy(frameBusy), .link(link.host));
  sfbm_flash_dev #(.ARRAY_BITS(12)) sfbm_flash_dev_inst (.sysClk(sysClk),
    .rstn(rstn), .ce(1'b1), .wrapSel(wrapSel), .quadMode(dQuad),
    .busy(dBusy), .link(link.dev));
  sfbm_link_props sfbm_link_props_inst (.sysClk(sysClk), .rstn(rstn),
    .quadMode(hQuad), .sck(link.sck), .csN(link.csN),
    .hostDo(link.hostDo), .hostOeN(link.hostOeN), .devOeN(link.devOeN));

  always #2 sysClk = ~sysClk;

  // Link clock rises per frame
  always @(posedge sysClk) begin
    sckP <= link.sck;
    csP <= link.csN;
    if (link.csN && !csP) frameRises <= rises;
    if (link.csN) rises <= 16'h0000;
    else if (!csP && link.sck && !sckP) rises <= rises + 16'h0001;
  end

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_val(string w, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask

  task automatic chk_cnt(string w, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %0d got %0d", w, e, g);
    end
  endtask

  task automatic give_up(string w);
    miscompares++;
    $display("mismatch %s exp done got timeout", w);
    stop_test();
  endtask

  task automatic chk_rd(logic [7:0] e[$]);
    chk_cnt("rdlen", 16'(e.size()), 16'(rdQ.size()));
    foreach (e[i]) chk_val("rd", e[i], rdQ[i]);
  endtask

  task automatic do_reset();
    @(negedge sysClk);
    rstn = 1'b0;
    repeat (6) @(negedge sysClk);
    rstn = 1'b1;
  endtask

  // One frame: offer, feed write bytes, collect read bytes, wait idle
  task automatic run_cmd(logic [7:0] op, logic [23:0] adr, logic [8:0] len,
      logic [7:0] wb[$], int stallCyc);
    int n;
    bit take;
    wrQ = wb;
    rdQ.delete();
    n = 0;
    take = 1'b0;
    @(negedge sysClk);
    if (cmdReady !== 1'b1) give_up("ready");
    cmdOp = op;
    cmdAddr = adr;
    cmdLen = len;
    wrValid = wrQ.size() > 0;
    wrData = wrValid ? wrQ[0] : 8'h00;
    cmdValid = 1'b1;
    do begin
      @(negedge sysClk);
      cmdValid = 1'b0;
      if (take) void'(wrQ.pop_front());
      wrValid = wrQ.size() > 0;
      wrData = wrValid ? wrQ[0] : 8'h00;
      take = wrReady && wrValid;
      rdReady = n >= stallCyc;
      if (rdReady && rdValid) rdQ.push_back(rdData);
      if (stallCyc > 0 && n == stallCyc)
        chk_val("stall", 8'h01, {7'h00, frameBusy});
      n++;
      if (n > 20000) give_up("frame");
    end while (!(cmdReady && !rdValid));
  endtask

  task automatic t_erased_read();
    run_cmd(sfbm_pkg::OP_READ, 24'h000100, 9'h004, noBytes, 0);
    chk_rd('{8'hff, 8'hff, 8'hff, 8'hff});
    chk_cnt("rises", 16'h0040, frameRises);
  endtask

  task automatic t_page_mode3();
    cmdMode3 = 1'b1;
    q = '{8'ha5, 8'h3c, 8'h5a, 8'hc3};
    run_cmd(sfbm_pkg::OP_PROG, 24'h0001fe, 9'h004, q, 0);
    run_cmd(sfbm_pkg::OP_DTR_READ, 24'h0001fe, 9'h004, noBytes, 0);
    chk_rd('{8'ha5, 8'h3c, 8'hff, 8'hff});
    chk_cnt("rises", 16'h0024, frameRises);
    run_cmd(sfbm_pkg::OP_READ, 24'h000100, 9'h002, noBytes, 0);
    chk_rd('{8'h5a, 8'hc3});
    cmdMode3 = 1'b0;
  endtask

  task automatic t_wrap();
    int w;
    int a;
    q = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    run_cmd(sfbm_pkg::OP_PROG, 24'h000300, 9'h008, q, 0);
    for (int s = 1; s <= 4; s++) begin
      wrapSel = 3'(s);
      w = 8 << (s - 1);
      run_cmd(sfbm_pkg::OP_READ, 24'h000306, 9'h00a, noBytes, 0);
      for (int i = 0; i < 10; i++) begin
        a = (6 + i) % w;
        chk_val("wrap", (a < 8) ? 8'(a) : sfbm_pkg::ERASED, rdQ[i]);
      end
    end
    wrapSel = 3'h0;
  endtask

  task automatic t_fifo_stall();
    run_cmd(sfbm_pkg::OP_READ, 24'h000300, 9'h028, noBytes, 6000);
    chk_cnt("rdlen", 16'h0028, 16'(rdQ.size()));
    for (int i = 0; i < 40; i++)
      chk_val("fifo", (i < 8) ? 8'(i) : sfbm_pkg::ERASED, rdQ[i]);
  endtask

  task automatic t_quad();
    run_cmd(sfbm_pkg::OP_ENTER4, 24'h000000, 9'h000, noBytes, 0);
    chk_cnt("rises", 16'h0008, frameRises);
    chk_val("dquad", 8'h01, {7'h00, dQuad});
    chk_val("hquad", 8'h01, {7'h00, hQuad});
    run_cmd(sfbm_pkg::OP_READ, 24'h000300, 9'h004, noBytes, 0);
    chk_rd('{8'h00, 8'h01, 8'h02, 8'h03});
    chk_cnt("rises", 16'h0010, frameRises);
    run_cmd(sfbm_pkg::OP_EXIT4, 24'h000000, 9'h000, noBytes, 0);
    chk_cnt("rises", 16'h0002, frameRises);
    chk_val("dquad", 8'h00, {7'h00, dQuad});
    chk_val("hquad", 8'h00, {7'h00, hQuad});
    run_cmd(sfbm_pkg::OP_READ, 24'h000301, 9'h001, noBytes, 0);
    chk_rd('{8'h01});
    chk_cnt("rises", 16'h0028, frameRises);
    run_cmd(sfbm_pkg::OP_ENTER4, 24'h000000, 9'h000, noBytes, 0);
    run_cmd(sfbm_pkg::OP_RST_EN, 24'h000000, 9'h000, noBytes, 0);
    run_cmd(sfbm_pkg::OP_RST, 24'h000000, 9'h000, noBytes, 0);
    chk_val("dquad", 8'h00, {7'h00, dQuad});
    chk_val("hquad", 8'h00, {7'h00, hQuad});
    do_reset();
    chk_val("hquad", 8'h00, {7'h00, hQuad});
    chk_val("dquad", 8'h00, {7'h00, dQuad});
  endtask

  task automatic t_erase();
    logic [7:0] ops[4];
    bit seen;
    int k;
    ops = '{sfbm_pkg::OP_ERS_4K, sfbm_pkg::OP_ERS_32K,
      sfbm_pkg::OP_ERS_64K, sfbm_pkg::OP_ERS_ALL};
    foreach (ops[j]) begin
      run_cmd(sfbm_pkg::OP_PROG, 24'h000800, 9'h001, '{8'h00}, 0);
      run_cmd(ops[j], 24'h000800, 9'h000, noBytes, 0);
      seen = 1'b0;
      for (k = 0; k < 10000; k++) begin
        @(negedge sysClk);
        if (dBusy) seen = 1'b1;
        if (!dBusy && (seen || k > 20)) break;
      end
      if (k >= 10000) give_up("erase");
      chk_val("busy", 8'h01, {7'h00, seen});
      run_cmd(sfbm_pkg::OP_READ, 24'h000800, 9'h001, noBytes, 0);
      chk_rd('{8'hff});
    end
  endtask

  initial begin
    do_reset();
    t_erased_read();
    t_page_mode3();
    t_wrap();
    t_fifo_stall();
    t_quad();
    t_erase();
    stop_test();
  end
endmodule
